// *** vatr_consts.vh ***
// Subaddresses, field positions, reset values and codes for the video adjust register group
`ifndef VATR_CONSTS_VH
`define VATR_CONSTS_VH
// ==========================================================
// Subaddresses
`define VATR_ADDR_HUE        8'h0c
`define VATR_ADDR_CHROMA_ONE 8'h0d
`define VATR_ADDR_CHROMA_TWO 8'h0e
`define VATR_ADDR_PR_GAIN    8'h10
`define VATR_ADDR_LUMA_GAIN  8'h11
`define VATR_ADDR_PB_GAIN    8'h12
`define VATR_ADDR_BLACK      8'h14
`define VATR_ADDR_AVS_LO     8'h16
`define VATR_ADDR_AVS_HI     8'h17
`define VATR_ADDR_AVE_LO     8'h18
`define VATR_ADDR_AVE_HI     8'h19
`define VATR_ADDR_HSS_LO     8'h1a
`define VATR_ADDR_HSS_HI     8'h1b
// ==========================================================
// Writable bit masks
`define VATR_MASK_CHROMA_ONE 8'h1b
`define VATR_MASK_CHROMA_TWO 8'h0f
`define VATR_MASK_AVS_HI     8'h0b
`define VATR_MASK_POS_HI     8'h03
// ==========================================================
// Field positions
`define VATR_BIT_PLL_RESET   4
`define VATR_BIT_COMB_OFF    3
`define VATR_BIT_PAL_COMP    3
`define VATR_BIT_WIDE_LPF    2
`define VATR_BIT_ACTIVE_BLK  3
// ==========================================================
// Reset values
`define VATR_RST_HUE         8'h00
`define VATR_RST_CHROMA_ONE  8'h00
`define VATR_RST_CHROMA_TWO  8'h0e
`define VATR_RST_GAIN        8'h80
`define VATR_RST_AVS_NTSC    10'h055
`define VATR_RST_AVS_PAL     10'h05f
`define VATR_RST_AVE_NTSC    10'h325
`define VATR_RST_AVE_PAL     10'h32f
`define VATR_RST_HSS         10'h000
// ==========================================================
// Codes and arithmetic constants
`define VATR_ACG_AUTO        2'b00
`define VATR_ACG_NOMINAL     2'b10
`define VATR_ACG_FREEZE      2'b11
`define VATR_NOTCH_OFF       2'b00
`define VATR_NOTCH_ONE       2'b01
`define VATR_NOTCH_TWO       2'b10
`define VATR_NOTCH_THREE     2'b11
`define VATR_UNITY           9'h080
`define VATR_BLACK_NOMINAL   11'h040
`define VATR_BLACK_OFFSET    11'h080
`endif

// *** vatr_regs.v ***
// Video adjust and timing register group of the decoder control space
//
// Contract
// - Hue is signed phase -180..+180 deg, default zero; composite/S-Video chroma only.
// - Subcarrier loop reset bit at one holds colour PLL in reset.
// - Adaptive comb bit active low, zero enables; composite input only.
// - Auto chroma gain: 00 auto, 10 nominal, 11 freeze, 01 reserved.
// - PAL compensation and wideband low-pass enables reset to one; zero disables.
// - Chroma filter: 00 off, 01/10/11 notch one/two/three, default two.
// - Component Pr gain equals nominal times setting over 128.
// - Component luma gain equals nominal times setting over 128.
// - Component Pb gain equals nominal times setting over 128.
// - Component black level equals 64 plus setting minus 128; settings below 64 clamp to zero.
// - Active-in-blank bit: zero flag active in blanking, one flag inactive.
// - Active video start ten bits from sync pixel zero; default 85 or 95.
// - Start-of-active-video code placed at active video start.
// - Active video stop ten bits from sync pixel zero; default 805 or 815.
// - End-of-active-video code placed per the active window setting.
// - Split positions apply only on upper byte write; low byte first.
// - Written positions survive standard changes until decoder reset.
// - Horizontal sync start ten bits, default zero, applied on upper byte write.
// - Each register reachable as an eight-bit subaddress over the host port.
`timescale 1ns/1ps
`include "vatr_consts.vh"

module vatr_regs (
    input  wire        clk_i,
    input  wire        resetn_i,
    input  wire        pal_std_i,
    input  wire        component_i,
    input  wire        composite_i,
    input  wire        wr_en_i,
    input  wire        rd_en_i,
    input  wire [7:0]  addr_i,
    input  wire [7:0]  wr_data_i,
    input  wire [9:0]  pixel_cnt_i,
    input  wire        vertical_blank_window_i,
    output reg  [7:0]  rd_data_o,
    output reg         rd_valid_o,
    output reg  [7:0]  hue_o,
    output reg         chroma_pll_reset_o,
    output reg         comb_enable_o,
    output reg  [1:0]  auto_chroma_gain_o,
    output reg         pal_comp_en_o,
    output reg         wideband_chroma_lowpass_o,
    output reg  [1:0]  notch_sel_o,
    output reg  [8:0]  pr_gain_o,
    output reg  [8:0]  luma_gain_o,
    output reg  [8:0]  pb_gain_o,
    output reg  [10:0] black_level_o,
    output reg  [9:0]  hsync_start_o,
    output reg         active_video_flag_o,
    output reg         sav_o,
    output reg         eav_o
);

    // ==========================================================
    // Storage
    reg  [7:0] hue;
    reg  [7:0] chroma_proc_ctrl_one;
    reg  [7:0] chroma_proc_ctrl_two;
    reg  [7:0] component_pr_gain;
    reg  [7:0] component_luma_gain;
    reg  [7:0] component_pb_gain;
    reg  [7:0] component_black_level;
    reg  [9:0] active_window_start;
    reg  [9:0] active_window_stop;
    reg  [9:0] hsync_start_position;
    reg  [7:0] avs_lo;
    reg  [7:0] ave_lo;
    reg  [7:0] hss_lo;
    reg        active_in_blank_select;
    reg        pos_written_start;
    reg        pos_written_stop;
    reg        pal_q1;
    reg        pal_q2;
    reg        comp_q1;
    reg        comp_q2;
    reg        cvbs_q1;
    reg        cvbs_q2;
    reg        vertical_blank_window_q1;
    reg        vertical_blank_window_q2;
    reg        in_window;
    reg  [7:0] next_rd_data;

    wire       wr_hit_avs = wr_en_i && (addr_i == `VATR_ADDR_AVS_HI);
    wire       wr_hit_ave = wr_en_i && (addr_i == `VATR_ADDR_AVE_HI);
    // Edge matches shared by the timing codes and the flag
    wire       start_hit  = (pixel_cnt_i == active_window_start);
    wire       stop_hit   = (pixel_cnt_i == active_window_stop);

    // Scales an eight-bit setting over 128; nine bits keep 255/128
    function [8:0] vatr_gain;
        input [7:0] setting;
        begin
            vatr_gain = {1'b0, setting};
        end
    endfunction

    // Window edge default for the standard in use
    function [9:0] vatr_std_default;
        input       pal;
        input [9:0] ntsc_value;
        input [9:0] pal_value;
        begin
            vatr_std_default = pal ? pal_value : ntsc_value;
        end
    endfunction

    // ==========================================================
    // Pin synchronisers
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            pal_q1  <= 1'b0;
            pal_q2  <= 1'b0;
            comp_q1 <= 1'b0;
            comp_q2 <= 1'b0;
            cvbs_q1 <= 1'b0;
            cvbs_q2 <= 1'b0;
            vertical_blank_window_q1 <= 1'b0;
            vertical_blank_window_q2 <= 1'b0;
        end else begin
            pal_q1  <= pal_std_i;
            pal_q2  <= pal_q1;
            comp_q1 <= component_i;
            comp_q2 <= comp_q1;
            cvbs_q1 <= composite_i;
            cvbs_q2 <= cvbs_q1;
            vertical_blank_window_q1 <= vertical_blank_window_i;
            vertical_blank_window_q2 <= vertical_blank_window_q1;
        end
    end

    // ==========================================================
    // Register writes
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            hue                    <= `VATR_RST_HUE;
            chroma_proc_ctrl_one   <= `VATR_RST_CHROMA_ONE;
            chroma_proc_ctrl_two   <= `VATR_RST_CHROMA_TWO;
            component_pr_gain      <= `VATR_RST_GAIN;
            component_luma_gain    <= `VATR_RST_GAIN;
            component_pb_gain      <= `VATR_RST_GAIN;
            component_black_level  <= `VATR_RST_GAIN;
            active_window_start    <= `VATR_RST_AVS_NTSC;
            active_window_stop     <= `VATR_RST_AVE_NTSC;
            hsync_start_position   <= `VATR_RST_HSS;
            avs_lo                 <= 8'h00;
            ave_lo                 <= 8'h00;
            hss_lo                 <= 8'h00;
            active_in_blank_select <= 1'b0;
            pos_written_start      <= 1'b0;
            pos_written_stop       <= 1'b0;
        end else begin
            // Defaults track the standard until software takes ownership
            if (!pos_written_start) begin
                active_window_start <= vatr_std_default(pal_q2, `VATR_RST_AVS_NTSC,
                                                        `VATR_RST_AVS_PAL);
            end
            if (!pos_written_stop) begin
                active_window_stop <= vatr_std_default(pal_q2, `VATR_RST_AVE_NTSC,
                                                       `VATR_RST_AVE_PAL);
            end
            if (wr_en_i) begin
                // Reserved bits masked off on write
                case (addr_i)
                    `VATR_ADDR_HUE:        hue <= wr_data_i;
                    `VATR_ADDR_CHROMA_ONE: chroma_proc_ctrl_one <= wr_data_i & `VATR_MASK_CHROMA_ONE;
                    `VATR_ADDR_CHROMA_TWO: chroma_proc_ctrl_two <= wr_data_i & `VATR_MASK_CHROMA_TWO;
                    `VATR_ADDR_PR_GAIN:    component_pr_gain <= wr_data_i;
                    `VATR_ADDR_LUMA_GAIN:  component_luma_gain <= wr_data_i;
                    `VATR_ADDR_PB_GAIN:    component_pb_gain <= wr_data_i;
                    `VATR_ADDR_BLACK:      component_black_level <= wr_data_i;
                    `VATR_ADDR_AVS_LO:     avs_lo <= wr_data_i;
                    `VATR_ADDR_AVE_LO:     ave_lo <= wr_data_i;
                    `VATR_ADDR_HSS_LO:     hss_lo <= wr_data_i;
                    `VATR_ADDR_HSS_HI: begin
                        hsync_start_position <= {wr_data_i[1:0], hss_lo};
                    end
                    `VATR_ADDR_AVS_HI: begin
                        active_in_blank_select <= wr_data_i[`VATR_BIT_ACTIVE_BLK];
                    end
                    default: begin
                    end
                endcase
            end
            // Low byte is staged; whole value lands on upper byte write
            if (wr_hit_avs) begin
                active_window_start <= {wr_data_i[1:0], avs_lo};
                pos_written_start   <= 1'b1;
            end
            if (wr_hit_ave) begin
                active_window_stop <= {wr_data_i[1:0], ave_lo};
                pos_written_stop   <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Read mux; window low bytes read back the applied position, not the staged byte
    always @* begin
        next_rd_data = 8'h00;
        case (addr_i)
            `VATR_ADDR_HUE:        next_rd_data = hue;
            `VATR_ADDR_CHROMA_ONE: next_rd_data = chroma_proc_ctrl_one;
            `VATR_ADDR_CHROMA_TWO: next_rd_data = chroma_proc_ctrl_two;
            `VATR_ADDR_PR_GAIN:    next_rd_data = component_pr_gain;
            `VATR_ADDR_LUMA_GAIN:  next_rd_data = component_luma_gain;
            `VATR_ADDR_PB_GAIN:    next_rd_data = component_pb_gain;
            `VATR_ADDR_BLACK:      next_rd_data = component_black_level;
            `VATR_ADDR_AVS_LO:     next_rd_data = active_window_start[7:0];
            `VATR_ADDR_AVS_HI:     next_rd_data = {4'h0, active_in_blank_select, 1'b0,
                                                   active_window_start[9:8]};
            `VATR_ADDR_AVE_LO:     next_rd_data = active_window_stop[7:0];
            `VATR_ADDR_AVE_HI:     next_rd_data = {6'h00, active_window_stop[9:8]};
            `VATR_ADDR_HSS_LO:     next_rd_data = hsync_start_position[7:0];
            `VATR_ADDR_HSS_HI:     next_rd_data = {6'h00, hsync_start_position[9:8]};
            default:               next_rd_data = 8'h00;
        endcase
    end

    always @(posedge clk_i) begin
        if (!resetn_i) begin
            rd_data_o  <= 8'h00;
            rd_valid_o <= 1'b0;
        end else begin
            // Data holds between reads; a late fetch still sees it
            rd_valid_o <= rd_en_i;
            if (rd_en_i) begin
                rd_data_o <= next_rd_data;
            end
        end
    end

    // ==========================================================
    // Settings toward the pixel pipeline
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            hue_o                     <= `VATR_RST_HUE;
            chroma_pll_reset_o        <= 1'b0;
            comb_enable_o             <= 1'b0;
            auto_chroma_gain_o        <= `VATR_ACG_AUTO;
            pal_comp_en_o             <= 1'b1;
            wideband_chroma_lowpass_o <= 1'b1;
            notch_sel_o               <= `VATR_NOTCH_TWO;
            pr_gain_o                 <= `VATR_UNITY;
            luma_gain_o               <= `VATR_UNITY;
            pb_gain_o                 <= `VATR_UNITY;
            black_level_o             <= `VATR_BLACK_NOMINAL;
            hsync_start_o             <= `VATR_RST_HSS;
        end else begin
            // Component input sees zero phase shift
            hue_o <= comp_q2 ? 8'h00 : hue;
            chroma_pll_reset_o <= chroma_proc_ctrl_one[`VATR_BIT_PLL_RESET];
            comb_enable_o <= cvbs_q2 && !chroma_proc_ctrl_one[`VATR_BIT_COMB_OFF];
            // Reserved code 01 falls back to automatic gain
            auto_chroma_gain_o <= (chroma_proc_ctrl_one[1:0] == 2'b01) ?
                                  `VATR_ACG_AUTO : chroma_proc_ctrl_one[1:0];
            pal_comp_en_o <= chroma_proc_ctrl_two[`VATR_BIT_PAL_COMP];
            wideband_chroma_lowpass_o <= chroma_proc_ctrl_two[`VATR_BIT_WIDE_LPF];
            notch_sel_o <= chroma_proc_ctrl_two[1:0];
            // Non-component paths keep unity gain; caller reads value/128
            pr_gain_o   <= comp_q2 ? vatr_gain(component_pr_gain) : `VATR_UNITY;
            luma_gain_o <= comp_q2 ? vatr_gain(component_luma_gain) : `VATR_UNITY;
            pb_gain_o   <= comp_q2 ? vatr_gain(component_pb_gain) : `VATR_UNITY;
            // Black level never underflows: 64 + 0 - 128 would, so clamp at zero
            if (!comp_q2) begin
                black_level_o <= `VATR_BLACK_NOMINAL;
            end else if ({3'b000, component_black_level} + `VATR_BLACK_NOMINAL
                         < `VATR_BLACK_OFFSET) begin
                black_level_o <= 11'h000;
            end else begin
                black_level_o <= {3'b000, component_black_level} + `VATR_BLACK_NOMINAL
                                 - `VATR_BLACK_OFFSET;
            end
            hsync_start_o <= hsync_start_position;
        end
    end

    // ==========================================================
    // Active window timing codes
    always @(posedge clk_i) begin
        if (!resetn_i) begin
            in_window           <= 1'b0;
            active_video_flag_o <= 1'b0;
            sav_o               <= 1'b0;
            eav_o               <= 1'b0;
        end else begin
            sav_o <= start_hit;
            eav_o <= stop_hit;
            // Start wins if both match; software keeps the two apart
            if (start_hit) begin
                in_window <= 1'b1;
            end else if (stop_hit) begin
                in_window <= 1'b0;
            end
            active_video_flag_o <= in_window && !(vertical_blank_window_q2 && active_in_blank_select);
        end
    end

endmodule // vatr_regs

// *** vatr_regs_props.sv ***
// Concurrent checks on the ports of the video adjust register group
`timescale 1ns/1ps
`include "vatr_consts.vh"
module vatr_props (
    input wire       clk_i,
    input wire       resetn_i,
    input wire       wr_en_i,
    input wire       rd_en_i,
    input wire [7:0] addr_i,
    input wire [7:0] wr_data_i,
    input wire       vertical_blank_window_i,
    input wire [7:0] rd_data_o,
    input wire       rd_valid_o,
    input wire       chroma_pll_reset_o,
    input wire [1:0] auto_chroma_gain_o,
    input wire       active_video_flag_o,
    input wire       sav_o,
    input wire       eav_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    // ==========================================================
    // Register bus
    read_answer_a: assert property (rd_en_i |=> rd_valid_o)
        else $error("read strobe got no valid pulse");
    read_quiet_a: assert property (!rd_en_i |=> !rd_valid_o)
        else $error("valid pulse without read strobe");
    read_hold_a: assert property (!rd_valid_o |-> $stable(rd_data_o))
        else $error("read data moved without a read");
    unmapped_zero_a: assert property (rd_en_i && addr_i > 8'h1b |=> rd_data_o == 8'h00)
        else $error("unmapped read not zero");
    pll_follow_a: assert property (wr_en_i && addr_i == `VATR_ADDR_CHROMA_ONE
        |-> ##2 chroma_pll_reset_o == $past(wr_data_i[4], 2))
        else $error("loop reset output not written value");
    gain_code_a: assert property (auto_chroma_gain_o != 2'b01)
        else $error("reserved gain code driven");
    // ==========================================================
    // Pixel timing
    flag_rise_a: assert property (sav_o && !$past(vertical_blank_window_i, 2)
        && !$past(vertical_blank_window_i, 3) |=> active_video_flag_o)
        else $error("flag not raised after start code");
    flag_fall_a: assert property (eav_o |=> !active_video_flag_o)
        else $error("flag not dropped after end code");
    codes_apart_a: assert property (!(sav_o && eav_o))
        else $error("start and end codes together");
endmodule // vatr_props

bind vatr_regs vatr_props i_vatr_props (.clk_i(clk_i), .resetn_i(resetn_i),
    .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .vertical_blank_window_i(vertical_blank_window_i), .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o), .chroma_pll_reset_o(chroma_pll_reset_o),
    .auto_chroma_gain_o(auto_chroma_gain_o), .active_video_flag_o(active_video_flag_o),
    .sav_o(sav_o), .eav_o(eav_o));

// *** testbench.sv ***
// Self-checking bench for the video adjust register group
`timescale 1ns/1ps
`include "vatr_consts.vh"
module testbench;
    reg         clk_i = 1'b0, resetn_i = 1'b0, pal_std_i = 1'b0, component_i = 1'b0;
    reg         composite_i = 1'b1, wr_en_i = 1'b0, rd_en_i = 1'b0, blank = 1'b0;
    reg  [7:0]  addr_i = 8'h00, wr_data_i = 8'h00;
    reg  [9:0]  pixel_cnt_i = 10'h000;
    wire [7:0]  rd_data_o, hue_o;
    wire [1:0]  acg, notch_sel_o;
    wire [8:0]  pr_gain_o, luma_gain_o, pb_gain_o;
    wire [10:0] black_level_o;
    wire [9:0]  hsync_start_o;
    wire        rd_valid_o, pll_rst, comb, pal_c, wide, flag, sav_o, eav_o;
    integer     num_errors = 0;
    integer     compares = 0;
    integer     i;

    vatr_regs i_vatr_regs (.clk_i(clk_i), .resetn_i(resetn_i), .pal_std_i(pal_std_i),
        .component_i(component_i), .composite_i(composite_i), .wr_en_i(wr_en_i),
        .rd_en_i(rd_en_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .pixel_cnt_i(pixel_cnt_i),
        .vertical_blank_window_i(blank), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
        .hue_o(hue_o), .chroma_pll_reset_o(pll_rst), .comb_enable_o(comb),
        .auto_chroma_gain_o(acg), .pal_comp_en_o(pal_c), .wideband_chroma_lowpass_o(wide),
        .notch_sel_o(notch_sel_o), .pr_gain_o(pr_gain_o), .luma_gain_o(luma_gain_o),
        .pb_gain_o(pb_gain_o), .black_level_o(black_level_o), .hsync_start_o(hsync_start_o),
        .active_video_flag_o(flag), .sav_o(sav_o), .eav_o(eav_o));

    initial begin
        forever #2 clk_i = ~clk_i;
    end
    // ==========================================================
    // Shared tasks
    task check(input string name, input logic [10:0] seen, input logic [10:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("MISMATCH %s expected %h seen %h", name, exp, seen);
            end
        end
    endtask
    task tick(input integer n);
        repeat (n) @(negedge clk_i);
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(negedge clk_i);
            addr_i = a; wr_data_i = d; wr_en_i = 1'b1;
            @(negedge clk_i);
            wr_en_i = 1'b0;
        end
    endtask
    task rd(input [7:0] a, input [7:0] exp);
        begin
            @(negedge clk_i);
            addr_i = a; rd_en_i = 1'b1;
            @(negedge clk_i);
            rd_en_i = 1'b0;
            check("rd_valid", rd_valid_o, 1'b1);
            check("rd_data", rd_data_o, exp);
        end
    endtask
    // Codes and flag follow the count one and two edges late
    task sweep(input logic en);
        integer v;
        reg [9:0] p1, p2;
        begin
            p1 = 10'h000; p2 = 10'h000;
            for (v = 316; v < 334; v = v + 1) begin
                @(negedge clk_i);
                check("sav", sav_o, p1 == 10'd320);
                check("eav", eav_o, p1 == 10'd328);
                check("flag", flag, en && p2 >= 10'd320 && p2 < 10'd328);
                p2 = p1; p1 = v[9:0]; pixel_cnt_i = v[9:0];
            end
            @(negedge clk_i);
            pixel_cnt_i = 10'h000;
        end
    endtask
    // ==========================================================
    // Scenarios
    task t_reset;
        begin
            check("pal_comp", pal_c, 1'b1);
            check("wide", wide, 1'b1);
            check("notch", notch_sel_o, 2'b10);
            check("black", black_level_o, 11'd64);
            check("hsync", hsync_start_o, 10'h000);
            rd(8'h0e, 8'h0e);
            rd(8'h10, 8'h80);
            rd(8'h16, 8'h55);
            rd(8'h18, 8'h25);
            rd(8'h19, 8'h03);
        end
    endtask
    task t_chroma;
        begin
            wr(8'h0d, 8'hff); tick(2);
            rd(8'h0d, 8'h1b);
            check("pll", pll_rst, 1'b1);
            check("comb", comb, 1'b0);
            for (i = 0; i < 4; i = i + 1) begin
                wr(8'h0d, i[7:0]); tick(2);
                check("acg", acg, (i == 1) ? 2'b00 : i[1:0]);
                check("comb", comb, 1'b1);
                wr(8'h0e, 8'h0c | i[7:0]); tick(2);
                check("notch", notch_sel_o, i[1:0]);
            end
            check("pll", pll_rst, 1'b0);
            wr(8'h0e, 8'h00); tick(2);
            check("pal_comp", pal_c, 1'b0);
            check("wide", wide, 1'b0);
        end
    endtask
    task t_component;
        begin
            component_i = 1'b1; composite_i = 1'b0;
            wr(8'h10, 8'h40); wr(8'h11, 8'hc0); wr(8'h12, 8'hff); wr(8'h14, 8'ha0);
            wr(8'h0c, 8'h81); tick(3);
            check("pr", pr_gain_o, 9'h040);
            check("luma", luma_gain_o, 9'h0c0);
            check("pb", pb_gain_o, 9'h0ff);
            check("black", black_level_o, 11'd96);
            check("hue", hue_o, 8'h00);
            check("comb", comb, 1'b0);
            component_i = 1'b0; composite_i = 1'b1; tick(4);
            check("hue", hue_o, 8'h81);
            check("pr", pr_gain_o, 9'h080);
        end
    endtask
    task t_position;
        begin
            wr(8'h16, 8'h40);
            rd(8'h16, 8'h55);
            wr(8'h17, 8'h01);
            rd(8'h16, 8'h40);
            pal_std_i = 1'b1; tick(4);
            rd(8'h18, 8'h2f);
            rd(8'h16, 8'h40);
            wr(8'h18, 8'h48); wr(8'h19, 8'h01);
            wr(8'h1a, 8'h34); tick(2);
            check("hsync", hsync_start_o, 10'h000);
            wr(8'h1b, 8'h06); tick(2);
            check("hsync", hsync_start_o, 10'h234);
            rd(8'h1b, 8'h02);
            wr(8'h2f, 8'hff);
            rd(8'h2f, 8'h00);
        end
    endtask
    task t_timing;
        begin
            sweep(1'b1);
            blank = 1'b1; tick(4);
            sweep(1'b1);
            wr(8'h17, 8'h09); tick(2);
            sweep(1'b0);
            rd(8'h17, 8'h09);
        end
    endtask
    // Mid-run reset reloads the window defaults for the standard now in use
    task t_rereset;
        begin
            tick(1);
            resetn_i = 1'b0;
            tick(2);
            resetn_i = 1'b1;
            tick(3);
            rd(8'h16, 8'h5f);
            rd(8'h18, 8'h2f);
            rd(8'h17, 8'h00);
            check("hsync", hsync_start_o, 10'h000);
        end
    endtask
    // ==========================================================
    // Sequencing and verdict
    task conclude;
        begin
            $display("compares %0d num_errors %0d", compares, num_errors);
            if (num_errors == 0 && compares > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    initial begin
        tick(6);
        resetn_i = 1'b1;
        tick(3);
        t_reset; t_chroma; t_component; t_position; t_timing; t_rereset;
        conclude;
    end
    initial begin
        #40000;
        num_errors = num_errors + 1;
        conclude;
    end
endmodule // testbench
